// ==== src/sys_ctl_pkg.sv ====
// Purpose: shared constants for the system reset / nmi vector unit
// Assumes: 16-bit peripheral bus, word-aligned byte addresses
// Notes:   cause tables map index i to vector code 2*(i+1)
package sys_ctl_pkg;

  // ==========================================================
  // register offsets
  localparam logic [15:0] ADDR_BERR_VEC = 16'h0198;
  localparam logic [15:0] ADDR_USER_VEC = 16'h019a;
  localparam logic [15:0] ADDR_SYS_VEC  = 16'h019c;
  localparam logic [15:0] ADDR_RST_VEC  = 16'h019e;
  localparam logic [15:0] ADDR_FLAGS    = 16'h0102;
  localparam logic [15:0] ADDR_WDOG     = 16'h0104;
  localparam logic [15:0] ADDR_PIN_CTL  = 16'h0106;
  localparam logic [15:0] ADDR_MAINT    = 16'h0108;
  localparam logic [15:0] ADDR_MB_IN    = 16'h010a;
  localparam logic [15:0] ADDR_MB_OUT   = 16'h010c;
  localparam logic [15:0] ADDR_SW_RST   = 16'h010e;

  // ==========================================================
  // flag register fields
  localparam int FLG_WDOG  = 0;
  localparam int FLG_OSC   = 1;
  localparam int FLG_VAC   = 3;
  localparam int FLG_PIN   = 4;
  localparam int FLG_MBIN  = 6;
  localparam int FLG_MBOUT = 7;
  localparam int FLG_SVM   = 8;
  localparam int FLG_BERR  = 9;
  localparam int FLG_W     = 10;
  localparam logic [FLG_W-1:0] FLG_RESET = 10'h000;

  // ==========================================================
  // reset causes, index order is priority order
  localparam int RC_BROWNOUT = 0;
  localparam int RC_SVS      = 1;
  localparam int RC_PIN      = 2;
  localparam int RC_DOBOR    = 3;
  localparam int RC_SECV     = 4;
  localparam int RC_DOPOR    = 5;
  localparam int RC_WDOG     = 6;
  localparam int RC_WKEY     = 7;
  localparam int RC_CKEY     = 8;
  localparam int RC_PKEY     = 9;
  localparam int RC_PFETCH   = 10;
  localparam int RC_N        = 11;
  localparam int RC_LAST_POR = RC_DOPOR;
  localparam logic [RC_N-1:0] RC_RESET = 11'h001;

  // ==========================================================
  // nmi group entries
  localparam int SN_SVM   = 0;
  localparam int SN_VAC   = 1;
  localparam int SN_MBIN  = 2;
  localparam int SN_MBOUT = 3;
  localparam int UN_PIN   = 0;
  localparam int UN_OSC   = 1;
  localparam int UN_BERR  = 2;

  // ==========================================================
  // control fields and keys
  localparam int PIN_NMI_EN   = 0;
  localparam logic [15:0] PIN_CTL_RO1 = 16'h000e;
  localparam int MAINT_LOCK   = 0;
  localparam int MAINT_SVMOUT = 1;
  localparam int SWR_POR      = 0;
  localparam int SWR_BOR      = 1;
  localparam logic [7:0] SW_RST_KEY    = 8'ha5;
  localparam logic [7:0] WDOG_KEY      = 8'h5a;
  localparam logic [7:0] WDOG_KEY_READ = 8'h69;
  localparam int WDOG_HOLD  = 7;
  localparam int WDOG_TMSEL = 4;
  localparam int WDOG_CLR   = 3;
  localparam logic [7:0] WDOG_CTL_RESET = 8'h00;
  localparam int WDOG_TAP0 = 15;
  localparam int WDOG_TAP1 = 13;
  localparam int WDOG_TAP2 = 9;
  localparam int WDOG_TAP3 = 6;
  localparam logic [15:0] PERIPH_TOP = 16'h1000;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PUC_HOLD_NS   = 100;
  localparam int PUC_CYCLES    = (PUC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_BLANK_CYCLES = 3;

  typedef enum logic [1:0] {SEQ_RUN, SEQ_HOLD, SEQ_BLANK} seq_t;

  // code of lowest set index, zero when nothing pending
  function automatic logic [15:0] vecCode(input logic [15:0] pend);
    vecCode = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      if (pend[i]) vecCode = 16'(2 * (i + 1));
    end
  endfunction

  // one-hot of the lowest set index
  function automatic logic [15:0] firstOne(input logic [15:0] pend);
    firstOne = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      if (pend[i]) firstOne = 16'h0001 << i;
    end
  endfunction

endpackage

// ==== src/sys_reset_nmi.sv ====
// Purpose: reset cause / nmi collection and vector generation
// Assumes: rst_b is the brownout / power-on reset; debug mailbox
//          strobes already on clk_sys; cpu strobes one cycle wide
// Notes:   reset, system and user vector reads return the top cause and clear it
// Functional notes
// - pending causes become readable vector codes
// - nmi causes routed to system or user group
// - por and puc levels, every cause classified
// - watchdog timeout 0Eh, key violation 10h, puc
// - peripheral-area fetch gives puc, code 16h
// - watchdog mode expiry resets the system
// - interval mode interrupts, never resets
// - lock bit protects lockable and calibration ram
// - debug mailbox with in and out flags
// - reset/nmi pin shared by four functions
// - vacant memory access sets its flag
// - watchdog flag set on overflow or key; pin/power clears
module sys_reset_nmi
  import sys_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // peripheral bus
  input  wire logic [15:0] busAddr,
  input  wire logic        busRd,
  input  wire logic        busWr,
  input  wire logic [15:0] busWdata,
  output      logic [15:0] busRdata,
  // cpu and system events
  input  wire logic        cpuFetch,
  input  wire logic [15:0] cpuFetchAddr,
  input  wire logic        vacantAccess,
  input  wire logic        busErrEvent,
  input  wire logic        secViolation,
  input  wire logic        clkKeyViol,
  input  wire logic        pmmKeyViol,
  input  wire logic        oscFault,
  // supply monitor and supervisor
  input  wire logic        svmTrip,
  input  wire logic        svsTrip,
  // reset / nmi pin
  input  wire logic        rstNmiIn,
  output      logic        rstNmiOut,
  output      logic        rstNmiOe,
  // debug mailbox
  input  wire logic        dbgPut,
  input  wire logic [15:0] dbgPutData,
  input  wire logic        dbgTake,
  output      logic [15:0] dbgGetData,
  // system outputs
  output      logic        pucOut,
  output      logic        porOut,
  output      logic        ramLock,
  output      logic        wdogIrq,
  output      logic        sysNmiReq,
  output      logic        userNmiReq
);

  // ==========================================================
  // input synchronisers
  logic [1:0] pinSync_q;
  logic [1:0] svmSync_q;
  logic [1:0] svsSync_q;
  logic       pinLevel_q;
  logic       svmLevel_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinSync_q  <= 2'b11;
      svmSync_q  <= 2'b00;
      svsSync_q  <= 2'b00;
      pinLevel_q <= 1'b1;
      svmLevel_q <= 1'b0;
    end else begin
      pinSync_q  <= {pinSync_q[0], rstNmiIn};
      svmSync_q  <= {svmSync_q[0], svmTrip};
      svsSync_q  <= {svsSync_q[0], svsTrip};
      pinLevel_q <= pinSync_q[1];
      svmLevel_q <= svmSync_q[1];
    end
  end

  // ==========================================================
  // bus decode
  logic rdRst, rdSys, rdUser, rdMbIn;
  logic wrFlags, wrWdog, wrPin, wrMaint, wrMbOut, wrSwRst;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_a);
    hit = (a == reg_a);
  endfunction

  assign rdRst   = busRd && hit(busAddr, ADDR_RST_VEC);
  assign rdSys   = busRd && hit(busAddr, ADDR_SYS_VEC);
  assign rdUser  = busRd && hit(busAddr, ADDR_USER_VEC);
  assign rdMbIn  = busRd && hit(busAddr, ADDR_MB_IN);
  assign wrFlags = busWr && hit(busAddr, ADDR_FLAGS);
  assign wrWdog  = busWr && hit(busAddr, ADDR_WDOG);
  assign wrPin   = busWr && hit(busAddr, ADDR_PIN_CTL);
  assign wrMaint = busWr && hit(busAddr, ADDR_MAINT);
  assign wrMbOut = busWr && hit(busAddr, ADDR_MB_OUT);
  assign wrSwRst = busWr && hit(busAddr, ADDR_SW_RST) && (busWdata[15:8] == SW_RST_KEY);

  // ==========================================================
  // watchdog
  logic [15:0] wdogCtrl;
  logic        wdogExpire, wdogKeyViol, wdogInterval;
  logic        pucActive;

  wdog_timer u_wdog (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .pucActive    (pucActive),
    .wrEn         (wrWdog),
    .wrData       (busWdata),
    .ctrlRead     (wdogCtrl),
    .expire       (wdogExpire),
    .keyViol      (wdogKeyViol),
    .intervalMode (wdogInterval)
  );

  // ==========================================================
  // control registers
  logic        nmiEn_q;
  logic [1:0]  maint_q;
  logic [15:0] mbIn_q;
  logic [15:0] mbOut_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nmiEn_q <= 1'b0;
    end else if (pucActive) begin
      nmiEn_q <= 1'b0;
    end else if (wrPin) begin
      nmiEn_q <= busWdata[PIN_NMI_EN];
    end
  end

  // lock survives puc so a crashing app cannot unlock its ram
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      maint_q <= 2'b00;
    end else if (porOut) begin
      maint_q <= 2'b00;
    end else if (wrMaint) begin
      maint_q <= busWdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mbIn_q  <= 16'h0000;
      mbOut_q <= 16'h0000;
    end else begin
      if (dbgPut) mbIn_q <= dbgPutData;
      if (wrMbOut) mbOut_q <= busWdata;
    end
  end

  // ==========================================================
  // pin handling; pin ignored while the reset sequencer drives it and for the blanking cycles after
  seq_t seq_q;
  logic pinBlank, pinFall, pinReset;

  assign pinBlank = (seq_q != SEQ_RUN);
  assign pinFall  = pinLevel_q && !pinSync_q[1];
  assign pinReset = !nmiEn_q && !pinSync_q[1] && !pinBlank;

  // ==========================================================
  // flags: hardware set wins over any clear
  logic [FLG_W-1:0]  flags_q, flagSet, flagClr, flagBase;
  logic [15:0]       sysPend, userPend, sysHit, userHit;

  assign sysPend  = {12'h000, flags_q[FLG_MBOUT], flags_q[FLG_MBIN],
                     flags_q[FLG_VAC], flags_q[FLG_SVM]};
  assign userPend = {13'h0000, flags_q[FLG_BERR], flags_q[FLG_OSC],
                     flags_q[FLG_PIN]};
  assign sysHit   = firstOne(sysPend);
  assign userHit  = firstOne(userPend);

  always_comb begin
    flagSet = '0;
    flagSet[FLG_WDOG]  = wdogExpire || wdogKeyViol;
    flagSet[FLG_OSC]   = oscFault;
    flagSet[FLG_VAC]   = vacantAccess;
    flagSet[FLG_PIN]   = nmiEn_q && pinFall && !pinBlank;
    flagSet[FLG_MBIN]  = dbgPut;
    flagSet[FLG_MBOUT] = dbgTake;
    flagSet[FLG_SVM]   = svmSync_q[1] && !svmLevel_q;
    flagSet[FLG_BERR]  = busErrEvent;
    flagClr = '0;
    flagClr[FLG_WDOG]  = pinReset;
    flagClr[FLG_MBIN]  = rdMbIn;
    flagClr[FLG_MBOUT] = wrMbOut;
    if (rdSys) begin
      flagClr[FLG_SVM]   = sysHit[SN_SVM];
      flagClr[FLG_VAC]   = sysHit[SN_VAC];
      flagClr[FLG_MBIN]  = sysHit[SN_MBIN] || rdMbIn;
      flagClr[FLG_MBOUT] = sysHit[SN_MBOUT] || wrMbOut;
    end
    if (rdUser) begin
      flagClr[FLG_PIN]  = userHit[UN_PIN];
      flagClr[FLG_OSC]  = userHit[UN_OSC];
      flagClr[FLG_BERR] = userHit[UN_BERR];
    end
    flagBase = wrFlags ? busWdata[FLG_W-1:0] : flags_q;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= FLG_RESET;
    end else begin
      flags_q <= (flagBase & ~flagClr) | flagSet;
    end
  end

  // ==========================================================
  // reset causes
  logic [RC_N-1:0] rc_q, rcSet, rcClr;
  logic [15:0]     rcHit;
  logic            porTrig, pucTrig;

  assign rcHit = firstOne(16'(rc_q));

  always_comb begin
    rcSet = '0;
    rcSet[RC_SVS]    = svsSync_q[1];
    rcSet[RC_PIN]    = pinReset;
    rcSet[RC_DOBOR]  = wrSwRst && busWdata[SWR_BOR];
    rcSet[RC_SECV]   = secViolation;
    rcSet[RC_DOPOR]  = wrSwRst && busWdata[SWR_POR];
    rcSet[RC_WDOG]   = wdogExpire && !wdogInterval;
    rcSet[RC_WKEY]   = wdogKeyViol;
    rcSet[RC_CKEY]   = clkKeyViol;
    rcSet[RC_PKEY]   = pmmKeyViol;
    rcSet[RC_PFETCH] = cpuFetch && (cpuFetchAddr < PERIPH_TOP);
    rcClr = rdRst ? rcHit[RC_N-1:0] : '0;
  end

  // causes up to the software por are por level, the rest puc
  assign porTrig = |rcSet[RC_LAST_POR:0];
  assign pucTrig = |rcSet;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rc_q <= RC_RESET;
    end else begin
      rc_q <= (rc_q & ~rcClr) | rcSet;
    end
  end

  // ==========================================================
  // reset sequencer
  logic [7:0] seqCnt_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      seq_q    <= SEQ_HOLD;
      seqCnt_q <= 8'(PUC_CYCLES);
      pucOut   <= 1'b1;
      porOut   <= 1'b1;
    end else begin
      case (seq_q)
        SEQ_RUN, SEQ_BLANK: begin
          // a cause during blanking still restarts the clear
          if (pucTrig) begin
            seq_q    <= SEQ_HOLD;
            seqCnt_q <= 8'(PUC_CYCLES);
            pucOut   <= 1'b1;
            porOut   <= porTrig;
          end else if (seq_q == SEQ_BLANK) begin
            if (seqCnt_q == 8'h00) seq_q <= SEQ_RUN;
            else seqCnt_q <= seqCnt_q - 8'h01;
          end
        end
        SEQ_HOLD: begin
          if (porTrig) porOut <= 1'b1;
          if (pucTrig) seqCnt_q <= 8'(PUC_CYCLES);
          else if (seqCnt_q == 8'h00) begin
            seq_q    <= SEQ_BLANK;
            seqCnt_q <= 8'(PIN_BLANK_CYCLES);
            pucOut   <= 1'b0;
            porOut   <= 1'b0;
          end else begin
            seqCnt_q <= seqCnt_q - 8'h01;
          end
        end
        default: seq_q <= SEQ_RUN;
      endcase
    end
  end

  assign pucActive = pucOut;

  // ==========================================================
  // registered outputs
  logic [15:0] rdMux;

  always_comb begin
    case (busAddr)
      ADDR_RST_VEC:  rdMux = vecCode(16'(rc_q));
      ADDR_SYS_VEC:  rdMux = vecCode(sysPend);
      ADDR_USER_VEC: rdMux = vecCode(userPend);
      ADDR_BERR_VEC: rdMux = 16'h0000;
      ADDR_FLAGS:    rdMux = 16'(flags_q);
      ADDR_WDOG:     rdMux = wdogCtrl;
      ADDR_PIN_CTL:  rdMux = PIN_CTL_RO1 | 16'(nmiEn_q);
      ADDR_MAINT:    rdMux = 16'(maint_q);
      ADDR_MB_IN:    rdMux = mbIn_q;
      ADDR_MB_OUT:   rdMux = mbOut_q;
      default:       rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busRdata   <= 16'h0000;
      rstNmiOut  <= 1'b0;
      rstNmiOe   <= 1'b1;
      ramLock    <= 1'b0;
      wdogIrq    <= 1'b0;
      sysNmiReq  <= 1'b0;
      userNmiReq <= 1'b0;
      dbgGetData <= 16'h0000;
    end else begin
      busRdata   <= busRd ? rdMux : 16'h0000;
      rstNmiOut  <= 1'b0;
      // open drain low: reset output, or supply monitor output
      rstNmiOe   <= (seq_q == SEQ_HOLD) || (maint_q[MAINT_SVMOUT] && svmLevel_q);
      ramLock    <= maint_q[MAINT_LOCK];
      wdogIrq    <= flags_q[FLG_WDOG] && wdogInterval;
      sysNmiReq  <= |sysPend;
      userNmiReq <= |userPend;
      dbgGetData <= mbOut_q;
    end
  end

endmodule

// ==== src/wdog_timer.sv ====
// Purpose: password-protected watchdog / interval timer
// Assumes: counts clk_sys; cleared by power-up clear
// Notes:   a bad key raises keyViol for one cycle
module wdog_timer
  import sys_ctl_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        pucActive,
  // control word access
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  output      logic [15:0] ctrlRead,
  // events
  output      logic        expire,
  output      logic        keyViol,
  output      logic        intervalMode
);

  logic [7:0]       ctl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] tapMask;
  logic             keyOk;

  assign keyOk        = (wrData[15:8] == WDOG_KEY);
  assign ctrlRead     = {WDOG_KEY_READ, ctl_q};
  assign intervalMode = ctl_q[WDOG_TMSEL];

  always_comb begin
    case (ctl_q[1:0])
      2'd0:    tapMask = CNT_W'((32'h1 << WDOG_TAP0) - 32'h1);
      2'd1:    tapMask = CNT_W'((32'h1 << WDOG_TAP1) - 32'h1);
      2'd2:    tapMask = CNT_W'((32'h1 << WDOG_TAP2) - 32'h1);
      default: tapMask = CNT_W'((32'h1 << WDOG_TAP3) - 32'h1);
    endcase
  end

  // ==========================================================
  // control register, clear bit is self-clearing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= WDOG_CTL_RESET;
    end else if (pucActive) begin
      ctl_q <= WDOG_CTL_RESET;
    end else if (wrEn && keyOk) begin
      ctl_q <= wrData[7:0] & ~(8'h01 << WDOG_CLR);
    end
  end

  // ==========================================================
  // interval counter
  assign expire  = !ctl_q[WDOG_HOLD] && ((cnt_q & tapMask) == tapMask);
  assign keyViol = wrEn && !keyOk;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else if (pucActive || expire || (wrEn && keyOk && wrData[WDOG_CLR])) begin
      cnt_q <= '0;
    end else if (!ctl_q[WDOG_HOLD]) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

// ==== tb/cpu_bus_model.sv ====
// Purpose: cpu side of the peripheral bus, word reads and writes
// Assumes: strobes one cycle wide, driven 1 ns after the edge
// Notes:   idle address and data show the inverse of the last value
module cpu_bus_model (
  // clock
  input  wire logic        clk_sys,
  // peripheral bus
  output      logic [15:0] busAddr,
  output      logic        busRd,
  output      logic        busWr,
  output      logic [15:0] busWdata,
  input  wire logic [15:0] busRdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    busAddr = 16'h0000;
    busRd = 1'b0;
    busWr = 1'b0;
    busWdata = 16'h0000;
  end

  // ====================
  // bus cycles
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    busAddr = a;
    busRd = 1'b1;
    @(posedge clk_sys);
    #1;
    busRd = 1'b0;
    busAddr = ~a;
    d = busRdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    busAddr = a;
    busWdata = d;
    busWr = 1'b1;
    @(posedge clk_sys);
    #1;
    busWr = 1'b0;
    busAddr = ~a;
    busWdata = ~d;
  endtask
endmodule

// ==== tb/sys_reset_nmi_checker.sv ====
// Purpose: port-level checks on the reset / nmi vector unit
// Assumes: one clock, rst_b async active low
// Notes:   bound to sys_reset_nmi, sees only its ports
module sys_reset_nmi_checker
  import sys_ctl_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // peripheral bus
  input wire logic [15:0] busAddr,
  input wire logic        busRd,
  input wire logic        busWr,
  input wire logic [15:0] busWdata,
  input wire logic [15:0] busRdata,
  // events
  input wire logic        cpuFetch,
  input wire logic [15:0] cpuFetchAddr,
  input wire logic        vacantAccess,
  input wire logic        busErrEvent,
  input wire logic        secViolation,
  input wire logic        clkKeyViol,
  // outputs
  input wire logic        rstNmiOut,
  input wire logic        pucOut,
  input wire logic        porOut,
  input wire logic        ramLock,
  input wire logic        wdogIrq,
  input wire logic        sysNmiReq,
  input wire logic        userNmiReq
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // ====================
  // reset levels
  chk_sec_por: assert property (secViolation |=> pucOut && porOut)
    else $error("security violation gave no por level");
  chk_key_puc: assert property (clkKeyViol && !porOut |=> pucOut && !porOut)
    else $error("clock key violation level wrong");
  chk_fetch_puc: assert property (cpuFetch && cpuFetchAddr < PERIPH_TOP |=> pucOut)
    else $error("peripheral fetch gave no puc");
  chk_por_puc: assert property (porOut |-> pucOut)
    else $error("por level without puc level");
  chk_puc_hold: assert property ($rose(pucOut) |=> pucOut [*8])
    else $error("puc level too short");
  chk_pin_low: assert property (rstNmiOut == 1'b0)
    else $error("pin drives high");

  // ====================
  // nmi and bus
  chk_vac_nmi: assert property (vacantAccess ##1 !(busRd || busWr) |=> sysNmiReq)
    else $error("vacant access raised no system nmi");
  chk_berr_nmi: assert property (busErrEvent ##1 !(busRd || busWr) |=> userNmiReq)
    else $error("bus error raised no user nmi");
  chk_rdata_idle: assert property (!busRd |=> busRdata == 16'h0000)
    else $error("read data without read");
  chk_rst_range: assert property (busRd && busAddr == ADDR_RST_VEC |=>
      busRdata <= 16'h0016 && !busRdata[0])
    else $error("reset vector code out of range");
  chk_berr_zero: assert property (busRd && busAddr == ADDR_BERR_VEC |=>
      busRdata == 16'h0000)
    else $error("bus error vector not zero");
  // lock register first, then the output flop
  chk_lock_wr: assert property (busWr && busAddr == ADDR_MAINT && !porOut |-> ##2
      ramLock == $past(busWdata[MAINT_LOCK], 2))
    else $error("lock bit did not follow write");

  cover property (busRd && busAddr == ADDR_RST_VEC ##1 busRdata != 16'h0000);
  cover property ($rose(wdogIrq));
  cover property ($rose(sysNmiReq));
endmodule

bind sys_reset_nmi sys_reset_nmi_checker chk_i (.clk_sys, .rst_b, .busAddr, .busRd,
  .busWr, .busWdata, .busRdata, .cpuFetch, .cpuFetchAddr, .vacantAccess, .busErrEvent,
  .secViolation, .clkKeyViol, .rstNmiOut, .pucOut, .porOut, .ramLock, .wdogIrq,
  .sysNmiReq, .userNmiReq);

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the reset / nmi vector unit
// Assumes: 100 MHz clk_sys, inputs change 1 ns after the edge
// Notes:   watchdog shortened by selecting the 2^6 interval
module testbench
  import sys_ctl_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk_sys, rst_b, busRd, busWr, cpuFetch, vacantAccess, busErrEvent;
  logic        secViolation, clkKeyViol, pmmKeyViol, oscFault, svmTrip, svsTrip;
  logic        pinExt, dbgPut, dbgTake, rstNmiOut, rstNmiOe, pucOut, porOut;
  logic        ramLock, wdogIrq, sysNmiReq, userNmiReq;
  logic [15:0] busAddr, busWdata, busRdata, cpuFetchAddr, dbgPutData, dbgGetData, d;
  int          fails, samples_checked, cycles, n;
  // open-drain pin with pull-up, the device can only pull it low
  wire logic   rstNmiIn = (rstNmiOe ? rstNmiOut : 1'b1) & pinExt;

  sys_reset_nmi sys_reset_nmi_i (.clk_sys, .rst_b, .busAddr, .busRd, .busWr, .busWdata,
    .busRdata, .cpuFetch, .cpuFetchAddr, .vacantAccess, .busErrEvent, .secViolation,
    .clkKeyViol, .pmmKeyViol, .oscFault, .svmTrip, .svsTrip, .rstNmiIn, .rstNmiOut,
    .rstNmiOe, .dbgPut, .dbgPutData, .dbgTake, .dbgGetData, .pucOut, .porOut, .ramLock,
    .wdogIrq, .sysNmiReq, .userNmiReq);
  cpu_bus_model cpu_i (.clk_sys, .busAddr, .busRd, .busWr, .busWdata, .busRdata);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // whole run is a few hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  // ====================
  // helpers
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic expect16(input logic [15:0] got, input logic [15:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      fails++;
    end
  endtask

  task automatic settle();
    n = 0;
    while (pucOut !== 1'b0 && n < 60) begin
      tick();
      n++;
    end
    expect16({15'h0, pucOut}, 16'h0000, "puc level stuck");
    repeat (6) tick();
  endtask

  // codes listed first to last in c, leftmost first
  task automatic drain(input logic [15:0] a, input logic [95:0] c, input int k);
    for (int i = 0; i < k; i++) begin
      cpu_i.rd(a, d);
      expect16(d, c[95 - 16 * i -: 16], "vector code");
    end
  endtask

  // ====================
  // scenarios
  task automatic t_boot();
    settle();
    expect16({14'h0, porOut, pucOut}, 16'h0000, "levels after boot");
    drain(ADDR_RST_VEC, {16'h0002, 16'h0000, 64'h0}, 2);
  endtask

  task automatic t_causes();
    clkKeyViol = 1'b1;
    pmmKeyViol = 1'b1;
    cpuFetch = 1'b1;
    cpuFetchAddr = 16'h0ffe;
    tick();
    clkKeyViol = 1'b0;
    pmmKeyViol = 1'b0;
    cpuFetch = 1'b0;
    // por causes one cycle later, so the puc-only level shows first
    svsTrip = 1'b1;
    secViolation = 1'b1;
    tick();
    svsTrip = 1'b0;
    secViolation = 1'b0;
    repeat (3) tick();
    expect16({14'h0, porOut, pucOut}, 16'h0003, "levels after causes");
    settle();
    drain(ADDR_RST_VEC, 96'h0004_000a_0012_0014_0016_0000, 6);
    cpuFetchAddr = PERIPH_TOP;
    cpuFetch = 1'b1;
    tick();
    cpuFetch = 1'b0;
    tick();
    expect16({15'h0, pucOut}, 16'h0000, "fetch above peripherals");
  endtask

  task automatic t_wdkey();
    cpu_i.wr(ADDR_WDOG, 16'h0013);
    repeat (2) tick();
    expect16({14'h0, porOut, pucOut}, 16'h0001, "key violation level");
    settle();
    cpu_i.rd(ADDR_FLAGS, d);
    expect16(d & 16'h0001, 16'h0001, "watchdog flag on key");
    drain(ADDR_RST_VEC, {16'h0010, 16'h0000, 64'h0}, 2);
  endtask

  task automatic t_wdexp();
    cpu_i.wr(ADDR_WDOG, {WDOG_KEY, 8'h0b});
    n = 0;
    while (pucOut !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    expect16(16'(n >= 55 && n <= 75), 16'h0001, "watchdog expiry time");
    settle();
    drain(ADDR_RST_VEC, {16'h000e, 16'h0000, 64'h0}, 2);
  endtask

  task automatic t_interval();
    cpu_i.wr(ADDR_FLAGS, 16'h0000);
    cpu_i.wr(ADDR_WDOG, {WDOG_KEY, 8'h1b});
    n = 0;
    while (wdogIrq !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    expect16({15'h0, wdogIrq}, 16'h0001, "interval interrupt");
    n = 0;
    repeat (140) begin
      tick();
      n += int'(pucOut);
    end
    expect16(16'(n), 16'h0000, "interval mode reset");
    cpu_i.wr(ADDR_WDOG, {WDOG_KEY, 8'h90});
  endtask

  task automatic t_nmi();
    svmTrip = 1'b1;
    vacantAccess = 1'b1;
    dbgPut = 1'b1;
    dbgPutData = 16'h3c5a;
    oscFault = 1'b1;
    busErrEvent = 1'b1;
    tick();
    vacantAccess = 1'b0;
    dbgPut = 1'b0;
    oscFault = 1'b0;
    busErrEvent = 1'b0;
    dbgTake = 1'b1;
    tick();
    dbgTake = 1'b0;
    repeat (4) tick();
    expect16({14'h0, sysNmiReq, userNmiReq}, 16'h0003, "nmi requests");
    drain(ADDR_SYS_VEC, 96'h0002_0004_0006_0008_0000_0000, 5);
    drain(ADDR_USER_VEC, {16'h0004, 16'h0006, 16'h0000, 48'h0}, 3);
    cpu_i.rd(ADDR_MB_IN, d);
    expect16(d, 16'h3c5a, "inbox word");
    expect16({14'h0, sysNmiReq, userNmiReq}, 16'h0000, "requests cleared");
    svmTrip = 1'b0;
  endtask

  task automatic t_misc();
    cpu_i.wr(ADDR_MAINT, 16'h0001);
    cpu_i.rd(ADDR_MAINT, d);
    expect16({15'h0, ramLock}, 16'h0001, "ram lock set");
    expect16(d & 16'h0001, 16'h0001, "lock readback");
    cpu_i.wr(ADDR_RST_VEC, 16'h0002);
    cpu_i.rd(ADDR_RST_VEC, d);
    expect16(d, 16'h0000, "vector written");
    cpu_i.rd(16'h0190, d);
    expect16(d, 16'h0000, "unmapped read");
    cpu_i.wr(ADDR_MB_OUT, 16'h5aa5);
    tick();
    expect16(dbgGetData, 16'h5aa5, "outbox word");
  endtask

  task automatic t_pin();
    pinExt = 1'b0;
    repeat (8) tick();
    pinExt = 1'b1;
    expect16({13'h0, rstNmiOe, porOut, pucOut}, 16'h0007, "pin reset levels");
    settle();
    cpu_i.rd(ADDR_FLAGS, d);
    expect16(d & 16'h0001, 16'h0000, "watchdog flag after pin");
    expect16({15'h0, ramLock}, 16'h0000, "lock after por");
    drain(ADDR_RST_VEC, {16'h0006, 16'h0000, 64'h0}, 2);
    // nmi mode: a 4-cycle pin pulse now raises the user nmi only
    cpu_i.wr(ADDR_PIN_CTL, 16'h0001);
    pinExt = 1'b0;
    repeat (4) tick();
    pinExt = 1'b1;
    expect16({15'h0, pucOut}, 16'h0000, "pin nmi gave reset");
    drain(ADDR_USER_VEC, {16'h0002, 16'h0000, 64'h0}, 2);
  endtask

  task automatic close_out();
    if (fails == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ====================
  // main sequence
  initial begin
    {rst_b, cpuFetch, vacantAccess, busErrEvent, secViolation, clkKeyViol} = 6'h00;
    {pmmKeyViol, oscFault, svmTrip, svsTrip, dbgPut, dbgTake} = 6'h00;
    {cpuFetchAddr, dbgPutData} = 32'h0;
    pinExt = 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    expect16({13'h0, rstNmiOe, porOut, pucOut}, 16'h0007, "levels in reset");
    rst_b = 1'b1;
    t_boot();
    t_causes();
    t_wdkey();
    t_wdexp();
    t_interval();
    t_nmi();
    t_misc();
    t_pin();
    close_out();
  end
endmodule
